// ===== src/srw_host.sv
// Host-side controller of a bidirectional supervisor reset line
`timescale 1ns/1ps
`include "srw_defines.svh"

module srw_host
    import srw_pkg::*;
(
    input  wire logic ref_clk_i,
    input  wire logic rstn_i,
    input  wire logic self_reset_req_i,
    input  wire logic kick_req_i,
    input  wire logic reset_line_i,
    output logic      reset_line_o,
    output logic      reset_line_oe_o,
    output logic      watchdog_kick_input_o,
    output logic      in_reset_o,
    output logic      cause_valid_o,
    output logic      cause_self_o
);

    localparam logic [2:0] DRIVE_LAST = 3'(`SRW_DRIVE_CYC - 3'h1);
    // Sync delay added so the decision sees the line as it stood at the sample point
    localparam logic [2:0] WAIT_LAST  = 3'(`SRW_SAMPLE_CYC + `SRW_SYNC_CYC - 3'h1);

    logic      rst_n;
    logic      line_s;
    srw_regs_t q;
    srw_regs_t d;

    // Reset release is synchronised so every state register flop leaves reset on the same edge
    srw_sync #(
        .WIDTH (1),
        .RST_V (1'h0)
    ) u_rst_sync (
        .clk_i  (ref_clk_i),
        .rstn_i (rstn_i),
        .d_i    (1'h1),
        .q_o    (rst_n)
    );

    // Line level comes from the pin and must be synchronised before use
    srw_sync #(
        .WIDTH (1),
        .RST_V (1'h1)
    ) u_line_sync (
        .clk_i  (ref_clk_i),
        .rstn_i (rstn_i),
        .d_i    (reset_line_i),
        .q_o    (line_s)
    );

    // Next-state logic for the whole controller
    always_comb
    begin
        d             = q;
        d.cause_valid = 1'h0;
        d.line_out    = `SRW_LINE_LOW;
        d.cnt         = q.cnt + 3'h1;
        case (q.state)
            SRW_IDLE:
            begin
                d.cnt = 3'h0;
                // Toggling the kick pin is what services the watchdog
                if (kick_req_i)
                begin
                    d.kick = !q.kick;
                end
                if (self_reset_req_i)
                begin
                    d.state    = SRW_DRIVE;
                    d.oe       = 1'h1;
                    d.in_reset = 1'h1;
                end
                else if (!line_s)
                begin
                    d.state    = SRW_EXT;
                    d.in_reset = 1'h1;
                end
            end
            SRW_DRIVE:
            begin
                if (q.cnt == DRIVE_LAST)
                begin
                    d.state = SRW_WAIT;
                    d.oe    = 1'h0;
                    d.cnt   = 3'h0;
                end
            end
            SRW_WAIT:
            begin
                if (q.cnt == WAIT_LAST)
                begin
                    d.cnt = 3'h0;
                    if (line_s)
                    begin
                        d.state       = SRW_IDLE;
                        d.in_reset    = 1'h0;
                        d.cause_valid = 1'h1;
                        d.cause_self  = 1'h1;
                    end
                    else
                    begin
                        d.state = SRW_EXT;
                    end
                end
            end
            SRW_EXT:
            begin
                d.cnt = 3'h0;
                if (line_s)
                begin
                    d.state       = SRW_IDLE;
                    d.in_reset    = 1'h0;
                    d.cause_valid = 1'h1;
                    d.cause_self  = 1'h0;
                end
            end
            default:
            begin
                d.state    = SRW_IDLE;
                d.oe       = 1'h0;
                d.in_reset = 1'h0;
                d.cnt      = 3'h0;
            end
        endcase
    end

    // State register; reset idles with the line released
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '{state: SRW_IDLE, cnt: 3'h0, oe: 1'h0, line_out: `SRW_LINE_LOW,
                   kick: 1'h0, in_reset: 1'h0, cause_valid: 1'h0, cause_self: 1'h0};
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign reset_line_o          = q.line_out;
    assign reset_line_oe_o       = q.oe;
    assign watchdog_kick_input_o = q.kick;
    assign in_reset_o            = q.in_reset;
    assign cause_valid_o         = q.cause_valid;
    assign cause_self_o          = q.cause_self;

    drive_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $rose(q.oe) |-> q.oe [*4] ##1 !q.oe)
        else $error("reset line not driven for exactly four cycles");

    low_only_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        q.oe |-> (q.line_out == 1'h0) && q.in_reset)
        else $error("reset line driven to a level other than low");

    self_cause_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        ($fell(q.oe) ##3 line_s) |=> q.cause_valid && q.cause_self)
        else $error("high line after release not reported as self reset");

    ext_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        ($fell(q.oe) ##3 !line_s) |=> (q.state == SRW_EXT) && !q.cause_valid)
        else $error("low line after release not treated as external");

    ext_report_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        (q.state == SRW_EXT && line_s) |=> q.cause_valid && !q.cause_self && !q.in_reset)
        else $error("external reset end not reported");

    cause_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        q.cause_valid |=> !q.cause_valid)
        else $error("cause report held longer than one cycle");

    sample_delay_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        $fell(q.oe) |-> (q.state == SRW_WAIT) [*4] ##1 (q.state != SRW_WAIT))
        else $error("line not sampled four cycles after release");

    self_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        ((q.state == SRW_IDLE) && self_reset_req_i) |=> q.oe && q.in_reset)
        else $error("own reset request not answered by driving the line");

    ext_entry_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        ((q.state == SRW_IDLE) && !self_reset_req_i && !line_s) |=>
            (q.state == SRW_EXT) && !q.oe && q.in_reset)
        else $error("line pulled low by another device not followed");

    drive_state_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
        q.oe |-> (q.state == SRW_DRIVE))
        else $error("line driven outside the drive phase");

endmodule

// ===== src/srw_defines.svh
// Timing constants for the host-side reset line controller
`ifndef SRW_DEFINES_SVH
`define SRW_DEFINES_SVH

// External clock cycles the host holds the reset line low
`define SRW_DRIVE_CYC   3'h4
// External clock cycles from release to sampling the line
`define SRW_SAMPLE_CYC  3'h2
// Depth of the input synchroniser, added to the sampling wait
`define SRW_SYNC_CYC    3'h2
// Reset state of the line output value (open drain pulls low only)
`define SRW_LINE_LOW    1'h0

`endif

// ===== src/srw_pkg.sv
// Types for the host-side reset line controller
package srw_pkg;

    typedef enum logic [1:0] {
        SRW_IDLE,
        SRW_DRIVE,
        SRW_WAIT,
        SRW_EXT
    } srw_state_t;

    typedef struct packed {
        srw_state_t state;
        logic [2:0] cnt;
        logic       oe;
        logic       line_out;
        logic       kick;
        logic       in_reset;
        logic       cause_valid;
        logic       cause_self;
    } srw_regs_t;

endpackage

// ===== src/srw_sync.sv
// Two flip-flop synchroniser with a constant reset value
`timescale 1ns/1ps
module srw_sync #(
    parameter int         WIDTH = 1,
    parameter logic [0:0] RST_V = 1'h0
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta_q;

    // First stage is read only by the second stage
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= {WIDTH{RST_V}};
            q_o    <= {WIDTH{RST_V}};
        end
        else
        begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

// ===== tb/srw_sup_model.sv
// Behavioural model of the supervisor on the shared reset line
`timescale 1ns/1ps
module srw_sup_model #(
    parameter int HOLD_CYC = 20,
    parameter int WD_CYC   = 60
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic uv_i,
    input  wire logic manual_reset_n_i,
    input  wire logic watchdog_kick_input_i,
    input  wire logic host_oe_i,
    input  wire logic host_val_i,
    input  wire logic wd_float_i,
    output logic      line_o
);
    int   hold_q;
    int   wd_q;
    logic kick_q;

    // Hold timer restarts while a cause lasts; the watchdog counts only outside reset
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            hold_q <= 0;
            wd_q   <= 0;
            kick_q <= 1'h0;
        end
        else
        begin
            kick_q <= watchdog_kick_input_i;
            if (uv_i || !manual_reset_n_i || wd_q >= WD_CYC)
                hold_q <= HOLD_CYC;
            else if (hold_q != 0)
                hold_q <= hold_q - 1;
            if (hold_q != 0 || (!wd_float_i && kick_q != watchdog_kick_input_i))
                wd_q <= 0;
            // a floating input clears itself at seven eighths of the period
            else if (wd_float_i && wd_q >= WD_CYC * 7 / 8)
                wd_q <= 0;
            else
                wd_q <= wd_q + 1;
        end
    end

    // open-drain wire
    // Digital model: the accelerated pullup restores high within one cycle
    assign line_o = !((host_oe_i && !host_val_i) || hold_q != 0);
endmodule

// ===== tb/test_srw_host.sv
// Self-checking bench of the host reset line controller
`timescale 1ns/1ps
module test_srw_host;
    logic ref_clk_i;
    logic rstn_i;
    logic self_req;
    logic kick_req;
    logic line;
    logic uv;
    logic mr_n;
    logic wd_float;
    logic line_o;
    logic oe;
    logic kick_o;
    logic in_reset;
    logic cause_valid;
    logic cause_self;
    int   errors;
    int   n_compared;

    srw_host u_srw_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .self_reset_req_i(self_req),
        .kick_req_i(kick_req), .reset_line_i(line), .reset_line_o(line_o),
        .reset_line_oe_o(oe), .watchdog_kick_input_o(kick_o), .in_reset_o(in_reset),
        .cause_valid_o(cause_valid), .cause_self_o(cause_self));
    srw_sup_model u_srw_sup_model (.clk_i(ref_clk_i), .rstn_i(rstn_i), .uv_i(uv),
        .manual_reset_n_i(mr_n), .watchdog_kick_input_i(kick_o), .host_oe_i(oe),
        .host_val_i(line_o), .wd_float_i(wd_float), .line_o(line));

    // 10 MHz clock
    initial
    begin
        ref_clk_i = 1'h0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic chk_n(input string name, input int exp, input int got);
        n_compared++;
        if (got != exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One kick pulse; the watchdog output must toggle on the next edge
    task automatic kick();
        logic was;
        was = kick_o;
        kick_req = 1'h1;
        @(negedge ref_clk_i);
        kick_req = 1'h0;
        chk("kick toggle", ~was, kick_o);
    endtask

    // Waits for the end-of-reset pulse and checks the reported cause
    task automatic wait_cause(input logic exp_self, input int limit, output int cyc);
        cyc = 0;
        while (cause_valid !== 1'h1 && cyc < limit)
        begin
            @(negedge ref_clk_i);
            cyc++;
        end
        chk("cause valid", 1'h1, cause_valid);
        chk("cause self", exp_self, cause_self);
        chk("in reset after", 1'h0, in_reset);
    endtask

    // Self reset on a free line: drive four cycles, decision nine cycles after request
    task automatic t_self();
        int cyc;
        int n_oe;
        kick();
        self_req = 1'h1;
        @(negedge ref_clk_i);
        self_req = 1'h0;
        n_oe = 0;
        cyc = 1;
        while (cause_valid !== 1'h1 && cyc < 30)
        begin
            n_oe += (oe === 1'h1) ? 1 : 0;
            chk("line value", 1'h0, line_o);
            @(negedge ref_clk_i);
            cyc++;
        end
        chk_n("drive cycles", 4, n_oe);
        chk_n("decision cycle", 9, cyc);
        wait_cause(1'h1, 1, cyc);
    endtask

    // Supervisor holds the line for undervoltage or manual reset: external cause
    task automatic t_external(input logic by_uv);
        int cyc;
        kick();
        uv = by_uv;
        mr_n = by_uv;
        // Pin low after one edge, two synchroniser edges, then one edge to enter
        repeat (4) @(negedge ref_clk_i);
        chk("in reset ext", 1'h1, in_reset);
        uv = 1'h0;
        mr_n = 1'h1;
        wait_cause(1'h0, 100, cyc);
        chk_n("hold longer than drive", 1, (cyc > 10) ? 1 : 0);
    endtask

    // Own reset taken just as the supervisor pulls the line low: decided external
    task automatic t_self_masked();
        int cyc;
        mr_n = 1'h0;
        @(negedge ref_clk_i);
        self_req = 1'h1;
        @(negedge ref_clk_i);
        self_req = 1'h0;
        chk("drive while held", 1'h1, oe);
        repeat (8) @(negedge ref_clk_i);
        chk("in reset after decision", 1'h1, in_reset);
        mr_n = 1'h1;
        wait_cause(1'h0, 100, cyc);
    endtask

    // Regular kicks keep the supervisor quiet; silence leads to a watchdog reset
    task automatic t_watchdog();
        int cyc;
        repeat (5)
        begin
            kick();
            repeat (30)
            begin
                @(negedge ref_clk_i);
                chk("no reset while kicked", 1'h0, in_reset);
            end
        end
        wait_cause(1'h0, 200, cyc);
        // Span starts 30 cycles after the last kick: 60 watchdog less 30, plus 20 hold
        chk_n("silent span", 1, (cyc > 50 && cyc < 70) ? 1 : 0);
    endtask

    // Floating watchdog input: no kicks for over two periods, yet no reset
    task automatic t_float();
        wd_float = 1'h1;
        repeat (150)
        begin
            @(negedge ref_clk_i);
            chk("no reset while floating", 1'h0, in_reset);
        end
        wd_float = 1'h0;
    endtask

    // Watchdog on the whole run
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        errors++;
        finish_test();
    end

    initial
    begin
        errors = 0;
        n_compared = 0;
        rstn_i = 1'h0;
        self_req = 1'h0;
        kick_req = 1'h0;
        uv = 1'h0;
        mr_n = 1'h1;
        wd_float = 1'h0;
        repeat (10) @(negedge ref_clk_i);
        rstn_i = 1'h1;
        repeat (4) @(negedge ref_clk_i);
        t_self();
        t_self();
        t_external(1'h1);
        t_external(1'h0);
        t_self_masked();
        t_watchdog();
        t_float();
        finish_test();
    end
endmodule
